// file: shared/gbc_pkg.sv
`default_nettype none
package gbc_pkg;
   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] OFS_SW_CONFIG     = 8'h00;
   localparam logic [7:0] OFS_HYST          = 8'h04;
   localparam logic [7:0] OFS_DAC_STAGE1_1  = 8'h08;
   localparam logic [7:0] OFS_DAC_STAGE1_2  = 8'h0c;
   localparam logic [7:0] OFS_DAC_DIRECT_1  = 8'h10;
   localparam logic [7:0] OFS_DAC_DIRECT_2  = 8'h14;
   localparam logic [7:0] OFS_LOAD_DAC      = 8'h18;
   localparam logic [7:0] OFS_CAL_CONTROL   = 8'h1c;
   localparam logic [7:0] OFS_ADC_SELECT    = 8'h20;
   localparam logic [7:0] OFS_SETPOINT      = 8'h24;
   localparam logic [7:0] OFS_PARAM_1       = 8'h28;
   localparam logic [7:0] OFS_PARAM_2       = 8'h2c;
   localparam logic [7:0] OFS_STATUS        = 8'h30;
   localparam logic [7:0] OFS_CH2_AVG       = 8'h34;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int SW_CH2_RATE     = 15;
   localparam int SW_CH2_CLAMP_LO = 12;
   localparam int SW_TCOMP2       = 10;
   localparam int SW_PCOMP2       = 9;
   localparam int SW_SRC2_LO      = 6;
   localparam int SW_TCOMP1       = 4;
   localparam int SW_PCOMP1       = 3;
   localparam int SW_SRC1_LO      = 0;
   localparam int CAL_TRACK_BIT   = 0;
   localparam int CAL_GO_BIT      = 1;
   localparam int CAL_PERIODIC    = 2;
   localparam int ADC_REPEAT_BIT  = 7;
   localparam int DAC_BITS        = 12;
   localparam int ADC_CHANNELS    = 7;

   // Source select codes
   localparam logic [1:0] SRC_PARAM_REG = 2'h0;
   localparam logic [1:0] SRC_RESERVED  = 2'h1;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [15:0] RST_SW_CONFIG = 16'h0000;
   localparam logic [3:0]  RST_HYST      = 4'h0;
   localparam logic [11:0] RST_DAC       = 12'h000;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_FREQ_KHZ     = 25000;
   localparam int CAL_INTERVAL_US  = 13000;
   localparam int CAL_INTERVAL_CYC = CAL_INTERVAL_US * CLK_FREQ_KHZ / 1000;
   localparam int CAL_CH_CYC       = 64;

   typedef enum logic [1:0] {
      CAL_IDLE, CAL_CH1, CAL_CH2, CAL_WAIT
   } gbc_cal_state_t;
endpackage
`default_nettype wire

// file: src/gbc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module gbc_ctrl #(
   parameter int CAL_INTERVAL = gbc_pkg::CAL_INTERVAL_CYC,
   parameter int CAL_CH_LEN   = gbc_pkg::CAL_CH_CYC
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // Analog status pins
   input  wire logic        i_tracking_mode,
   input  wire logic [1:0]  i_ch_pd,
   // Samples from converter
   input  wire logic [1:0]  i_temp_valid,
   input  wire logic [11:0] i_temp_data,
   input  wire logic [1:0]  i_cur_valid,
   input  wire logic [11:0] i_cur_data,
   input  wire logic [1:0]  i_aux_valid,
   input  wire logic [11:0] i_aux_data,
   input  wire logic        i_adc_done,
   // Gate DAC codes
   output logic      [11:0] o_gate_code_ch1,
   output logic      [11:0] o_gate_code_ch2,
   // Calculation triggers
   output logic      [1:0]  o_calc_trig,
   // Amplifier calibration
   output logic      [1:0]  o_cal_active,
   output logic             o_cal_track,
   output logic             o_nv_cal_store,
   output logic      [2:0]  o_nv_cal_data,
   // ADC control
   output logic      [6:0]  o_adc_chan_en,
   output logic             o_adc_repeat_en,
   output logic             o_adc_start,
   output logic      [2:0]  o_adc_chan
);
   // ************************************************************
   // Helpers
   // ************************************************************
   // True when two codes differ by more than the hysteresis
   function automatic logic beyond(input logic [11:0] a,
                                   input logic [11:0] b,
                                   input logic [3:0]  h);
      logic [11:0] d;
      d = (a > b) ? a - b : b - a;
      return d > {8'h00, h};
   endfunction

   // Clamp a signed difference to 2^code-1; code 0 passes it unclamped
   function automatic logic signed [12:0] clamp(
      input logic signed [12:0] d, input logic [2:0] code);
      logic signed [12:0] lim;
      lim = $signed((13'h0001 << code) - 13'h0001);
      if (code == 3'h0)
         return d;
      else if (d > lim)
         return lim;
      else if (d < -lim)
         return -lim;
      else
         return d;
   endfunction

   // ************************************************************
   // Synchronisers for analog status pins
   // ************************************************************
   logic [2:0] meta;
   logic [2:0] sync;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         meta <= 3'h0;
         sync <= 3'h0;
      end else begin
         meta <= {i_tracking_mode, i_ch_pd};
         sync <= meta;
      end
   end
   wire       tracking = sync[2];
   wire [1:0] ch_pd    = sync[1:0];

   // ************************************************************
   // Register decode
   // ************************************************************
   wire wr_cfg  = i_wr && (i_addr == gbc_pkg::OFS_SW_CONFIG);
   wire wr_hyst = i_wr && (i_addr == gbc_pkg::OFS_HYST);
   wire wr_s1a  = i_wr && (i_addr == gbc_pkg::OFS_DAC_STAGE1_1);
   wire wr_s1b  = i_wr && (i_addr == gbc_pkg::OFS_DAC_STAGE1_2);
   wire wr_dra  = i_wr && (i_addr == gbc_pkg::OFS_DAC_DIRECT_1);
   wire wr_drb  = i_wr && (i_addr == gbc_pkg::OFS_DAC_DIRECT_2);
   wire wr_load = i_wr && (i_addr == gbc_pkg::OFS_LOAD_DAC);
   wire wr_cal  = i_wr && (i_addr == gbc_pkg::OFS_CAL_CONTROL);
   wire wr_adc  = i_wr && (i_addr == gbc_pkg::OFS_ADC_SELECT);
   wire wr_set  = i_wr && (i_addr == gbc_pkg::OFS_SETPOINT);
   wire wr_p1   = i_wr && (i_addr == gbc_pkg::OFS_PARAM_1);
   wire wr_p2   = i_wr && (i_addr == gbc_pkg::OFS_PARAM_2);
   wire [11:0] wdac = i_wdata[gbc_pkg::DAC_BITS-1:0];  // Top nibble dropped

   logic [15:0] sw_cfg;
   logic [3:0]  hyst;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sw_cfg <= gbc_pkg::RST_SW_CONFIG;
         hyst   <= gbc_pkg::RST_HYST;
      end else begin
         if (wr_cfg)
            sw_cfg <= i_wdata;
         if (wr_hyst)
            hyst <= i_wdata[3:0];  // Shared by both channels
      end
   end

   wire       ch2_rate  = sw_cfg[gbc_pkg::SW_CH2_RATE];
   wire [2:0] ch2_clamp = sw_cfg[gbc_pkg::SW_CH2_CLAMP_LO +: 3];
   wire [1:0] temp_comp_en     = {sw_cfg[gbc_pkg::SW_TCOMP2],
                           sw_cfg[gbc_pkg::SW_TCOMP1]};
   wire [1:0] pcomp     = {sw_cfg[gbc_pkg::SW_PCOMP2],
                           sw_cfg[gbc_pkg::SW_PCOMP1]};
   wire [1:0] src [2];
   assign src[0] = sw_cfg[gbc_pkg::SW_SRC1_LO +: 2];
   assign src[1] = sw_cfg[gbc_pkg::SW_SRC2_LO +: 2];

   // ************************************************************
   // Two-stage gate DAC registers
   // ************************************************************
   // Nothing here feeds the storage port: DAC values are volatile
   logic [11:0] stage1 [2];
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         stage1[0]       <= gbc_pkg::RST_DAC;
         stage1[1]       <= gbc_pkg::RST_DAC;
         o_gate_code_ch1 <= gbc_pkg::RST_DAC;
         o_gate_code_ch2 <= gbc_pkg::RST_DAC;
      end else begin
         if (wr_s1a || wr_dra)
            stage1[0] <= wdac;
         if (wr_s1b || wr_drb)
            stage1[1] <= wdac;
         if (wr_dra)
            o_gate_code_ch1 <= wdac;  // Both stages at once
         else if (wr_load && i_wdata[0])
            o_gate_code_ch1 <= stage1[0];
         if (wr_drb)
            o_gate_code_ch2 <= wdac;
         else if (wr_load && i_wdata[1])
            o_gate_code_ch2 <= stage1[1];
      end
   end

   // ************************************************************
   // Channel 2 temperature average
   // ************************************************************
   // Four fraction bits keep the 1/16 step exact without rounding
   logic [15:0] ch2_avg_fx;
   wire  signed [12:0] ch2_diff = $signed({1'b0, i_temp_data})
                                - $signed({1'b0, ch2_avg_fx[15:4]});
   wire  signed [12:0] ch2_lim  = clamp(ch2_diff, ch2_clamp);
   wire         fast_rate = tracking && ch2_rate;
   wire  signed [16:0] ch2_step = fast_rate ?
                        17'(ch2_lim) <<< 2 : 17'(ch2_lim);
   wire  [15:0] next_ch2_avg = 16'($signed({1'b0, ch2_avg_fx}) + ch2_step);
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         ch2_avg_fx <= 16'h0000;
      else if (i_temp_valid[1])
         ch2_avg_fx <= next_ch2_avg;
   end

   // ************************************************************
   // Calculation trigger logic
   // ************************************************************
   logic [11:0] last_temp  [2];
   logic [11:0] last_param [2];
   logic [1:0]  temp_hit;
   logic [1:0]  param_hit;
   logic [1:0]  param_wr;
   logic [11:0] temp_val   [2];
   logic [11:0] param_val  [2];
   logic [1:0]  param_vld;
   assign param_wr    = {wr_p2, wr_p1};
   assign temp_val[0] = i_temp_data;
   assign temp_val[1] = ch2_avg_fx[15:4];  // Ch2 compares the average

   for (genvar c = 0; c < 2; c++) begin : g_trig
      // Source 01 is never selected by software, so it picks nothing
      assign param_vld[c] = src[c][1] &&
                            (src[c][0] ? i_aux_valid[c] : i_cur_valid[c]);
      assign param_val[c] = src[c][0] ? i_aux_data : i_cur_data;
      assign temp_hit[c]  = temp_comp_en[c] && i_temp_valid[c] &&
                 beyond(temp_val[c], last_temp[c], hyst);
      assign param_hit[c] = pcomp[c] && (param_vld[c] &&
                 beyond(param_val[c], last_param[c], hyst)
               || (src[c] == gbc_pkg::SRC_PARAM_REG) && param_wr[c]);

      always_ff @(posedge i_core_clk or posedge i_rst) begin
         if (i_rst) begin
            last_temp[c]  <= 12'h000;
            last_param[c] <= 12'h000;
         end else begin
            if (temp_hit[c])
               last_temp[c] <= temp_val[c];
            if (param_hit[c] && param_vld[c])
               last_param[c] <= param_val[c];  // Last sample used
         end
      end
   end

   // One-cycle trigger, registered
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         o_calc_trig <= 2'h0;
      else
         o_calc_trig <= temp_hit | param_hit | {2{wr_set}};
   end

   // ************************************************************
   // Amplifier calibration sequencer
   // ************************************************************
   gbc_pkg::gbc_cal_state_t cal_state, next_cal_state;
   logic [2:0]  cal_ctl;  // Periodic, go, track
   logic [18:0] cal_cnt;
   logic        cal_pend;
   wire go_write   = wr_cal && i_wdata[gbc_pkg::CAL_GO_BIT];
   wire periodic   = cal_ctl[gbc_pkg::CAL_PERIODIC];
   wire cal_go     = cal_ctl[gbc_pkg::CAL_GO_BIT];
   wire cnt_done   = (cal_cnt == 19'h00000);
   wire start_cal  = (cal_state == gbc_pkg::CAL_IDLE && cal_pend) ||
                     (cal_state == gbc_pkg::CAL_WAIT && cnt_done &&
                      periodic && cal_go);
   wire seq_end    = (cal_state == gbc_pkg::CAL_CH2 && cnt_done) ||
                     (cal_state == gbc_pkg::CAL_CH1 && cnt_done && ch_pd[1]);

   // Next state: powered-down channels are stepped over
   always_comb begin
      next_cal_state = cal_state;
      unique case (cal_state)
         gbc_pkg::CAL_IDLE, gbc_pkg::CAL_WAIT:
            if (start_cal)
               next_cal_state = !ch_pd[0] ? gbc_pkg::CAL_CH1 :
                                !ch_pd[1] ? gbc_pkg::CAL_CH2 :
                                (periodic ? gbc_pkg::CAL_WAIT
                                          : gbc_pkg::CAL_IDLE);
            else if (cal_state == gbc_pkg::CAL_WAIT && !(periodic && cal_go))
               next_cal_state = gbc_pkg::CAL_IDLE;
         gbc_pkg::CAL_CH1:
            if (cnt_done)
               next_cal_state = !ch_pd[1] ? gbc_pkg::CAL_CH2 :
                                periodic ? gbc_pkg::CAL_WAIT
                                         : gbc_pkg::CAL_IDLE;
         gbc_pkg::CAL_CH2:
            if (cnt_done)
               next_cal_state = periodic ? gbc_pkg::CAL_WAIT
                                         : gbc_pkg::CAL_IDLE;
      endcase
   end

   // Counter reloads on every state change
   wire [18:0] next_cal_cnt =
      (next_cal_state == gbc_pkg::CAL_WAIT) ? 19'(CAL_INTERVAL - 1) :
                                              19'(CAL_CH_LEN - 1);
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cal_state <= gbc_pkg::CAL_IDLE;
         cal_cnt   <= 19'h00000;
      end else begin
         cal_state <= next_cal_state;
         if (next_cal_state != cal_state)
            cal_cnt <= next_cal_cnt;
         else if (!cnt_done)
            cal_cnt <= cal_cnt - 19'h00001;
      end
   end

   // Control bits: a write lands over the self-clear
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cal_ctl  <= 3'h0;
         cal_pend <= 1'b0;
      end else begin
         if (wr_cal)
            cal_ctl <= i_wdata[2:0];  // Bits 15..3 ignored
         else if (seq_end && !periodic)
            cal_ctl[gbc_pkg::CAL_GO_BIT] <= 1'b0;
         if (go_write)
            cal_pend <= 1'b1;  // One manual run per go write
         else if (start_cal)
            cal_pend <= 1'b0;
      end
   end

   // Storage copy of calibration control
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_nv_cal_store <= 1'b0;
         o_nv_cal_data  <= 3'h0;
      end else begin
         o_nv_cal_store <= wr_cal;
         if (wr_cal)
            o_nv_cal_data <= i_wdata[2:0];
      end
   end

   assign o_cal_active = {cal_state == gbc_pkg::CAL_CH2,
                          cal_state == gbc_pkg::CAL_CH1};
   assign o_cal_track  = cal_ctl[gbc_pkg::CAL_TRACK_BIT];

   // ************************************************************
   // ADC channel selection and sequencing
   // ************************************************************
   // A select write scans its own new enables, so the first start
   // always lands on a channel that is really selected
   wire [6:0] scan_en = wr_adc ? i_wdata[6:0] : o_adc_chan_en;
   // Next enabled channel after the current one, wrapping
   logic [2:0] next_chan;
   always_comb begin
      next_chan = o_adc_chan;
      for (int k = 7; k >= 1; k--) begin
         if (scan_en[3'((32'(o_adc_chan) + k) % 7)])
            next_chan = 3'((32'(o_adc_chan) + k) % 7);
      end
   end
   wire adc_go = (wr_adc && |i_wdata[6:0]) ||
                 (i_adc_done && o_adc_repeat_en && |o_adc_chan_en);
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_adc_chan_en   <= 7'h00;
         o_adc_repeat_en <= 1'b0;
         o_adc_start     <= 1'b0;
         o_adc_chan      <= 3'h6;
      end else begin
         if (wr_adc) begin
            o_adc_chan_en   <= i_wdata[6:0];
            o_adc_repeat_en <= i_wdata[gbc_pkg::ADC_REPEAT_BIT];
         end
         o_adc_start <= adc_go;
         if (adc_go)
            o_adc_chan <= next_chan;
      end
   end
   // ************************************************************
   // Read path: status and channel 2 average
   // ************************************************************
   wire [15:0] status = {8'h00, o_adc_repeat_en, o_adc_start,
                         ch_pd, tracking, cal_pend, cal_go,
                         cal_state != gbc_pkg::CAL_IDLE};
   wire [15:0] rd_mux = (i_addr == gbc_pkg::OFS_STATUS)  ? status :
                        (i_addr == gbc_pkg::OFS_CH2_AVG) ?
                           {4'h0, ch2_avg_fx[15:4]} : 16'h0000;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst)
         o_rdata <= 16'h0000;
      else
         o_rdata <= i_rd ? rd_mux : 16'h0000;
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_direct_dac;
      @(posedge i_core_clk) disable iff (i_rst)
      wr_dra |=> o_gate_code_ch1 == $past(wdac) && stage1[0] == $past(wdac);
   endproperty
   a_direct_dac: assert property (p_direct_dac)
      else $error("direct dac write did not reach both stages");

   property p_stage1_hold;
      @(posedge i_core_clk) disable iff (i_rst)
      wr_s1a && !wr_load |=> $stable(o_gate_code_ch1);
   endproperty
   a_stage1_hold: assert property (p_stage1_hold)
      else $error("stage one write moved the gate");

   property p_load;
      @(posedge i_core_clk) disable iff (i_rst)
      wr_load && i_wdata[1] |=> o_gate_code_ch2 == $past(stage1[1]);
   endproperty
   a_load: assert property (p_load)
      else $error("load did not copy stage one");

   property p_no_trig_dac;
      @(posedge i_core_clk) disable iff (i_rst)
      (wr_s1a || wr_dra) && !temp_hit[0] && !param_hit[0]
         |=> !o_calc_trig[0];
   endproperty
   a_no_trig_dac: assert property (p_no_trig_dac)
      else $error("dac write triggered a calculation");

   property p_setpoint;
      @(posedge i_core_clk) disable iff (i_rst)
      wr_set |=> o_calc_trig == 2'h3;
   endproperty
   a_setpoint: assert property (p_setpoint)
      else $error("setpoint write missed a trigger");

   property p_param_reg;
      @(posedge i_core_clk) disable iff (i_rst)
      wr_p1 && pcomp[0] && src[0] == 2'h0 |=> o_calc_trig[0];
   endproperty
   a_param_reg: assert property (p_param_reg)
      else $error("parameter write missed a trigger");

   property p_hyst;
      @(posedge i_core_clk) disable iff (i_rst)
      pcomp[0] && src[0] == 2'h2 && i_cur_valid[0] && !wr_set &&
      !temp_hit[0] && !beyond(i_cur_data, last_param[0], hyst)
         |=> !o_calc_trig[0];
   endproperty
   a_hyst: assert property (p_hyst)
      else $error("sample inside hysteresis triggered");

   property p_rate;
      @(posedge i_core_clk) disable iff (i_rst)
      i_temp_valid[1] && !fast_rate && ch2_clamp == 3'h0
         |=> ch2_avg_fx == 16'($past(ch2_avg_fx) + 16'($past(ch2_diff)));
   endproperty
   a_rate: assert property (p_rate)
      else $error("slow average step wrong");

   property p_go_clear;
      @(posedge i_core_clk) disable iff (i_rst)
      seq_end && !periodic && !wr_cal |=> !cal_go;
   endproperty
   a_go_clear: assert property (p_go_clear)
      else $error("go bit not cleared at finish");

   property p_skip;
      @(posedge i_core_clk) disable iff (i_rst)
      ch_pd[0] && cal_state != gbc_pkg::CAL_CH1 |=> !o_cal_active[0];
   endproperty
   a_skip: assert property (p_skip)
      else $error("powered-down channel calibrated");

   property p_adc_start;
      @(posedge i_core_clk) disable iff (i_rst)
      wr_adc && i_wdata[6:0] != 7'h00 |=> o_adc_start;
   endproperty
   a_adc_start: assert property (p_adc_start)
      else $error("select write started nothing");

   c_periodic: cover property (@(posedge i_core_clk) disable iff (i_rst)
      cal_state == gbc_pkg::CAL_WAIT && start_cal);
   c_repeat: cover property (@(posedge i_core_clk) disable iff (i_rst)
      o_adc_repeat_en && i_adc_done ##1 o_adc_start);
   c_clamp: cover property (@(posedge i_core_clk) disable iff (i_rst)
      i_temp_valid[1] && ch2_lim != ch2_diff);
endmodule

`default_nettype wire

// file: test/gbc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Register-level bench
// ************************************************************
module gbc_ctrl_test;
   logic        i_core_clk, i_rst, i_wr, i_rd, i_tracking_mode;
   logic [7:0]  i_addr;
   logic [15:0] i_wdata, o_rdata;
   logic [1:0]  i_ch_pd, i_temp_valid, i_cur_valid, i_aux_valid;
   logic [11:0] i_temp_data, i_cur_data, i_aux_data, g1, g2;
   logic        i_adc_done, o_cal_track, o_nv, o_start, o_rep;
   logic [1:0]  o_trig, o_act;
   logic [2:0]  o_nvd, o_chan;
   logic [6:0]  o_en;
   int          err_total, samples_checked;
   gbc_ctrl #(.CAL_INTERVAL(50), .CAL_CH_LEN(8)) DUT (.i_core_clk,
      .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_tracking_mode, .i_ch_pd, .i_temp_valid, .i_temp_data,
      .i_cur_valid, .i_cur_data, .i_aux_valid, .i_aux_data, .i_adc_done,
      .o_gate_code_ch1(g1), .o_gate_code_ch2(g2), .o_calc_trig(o_trig),
      .o_cal_active(o_act), .o_cal_track, .o_nv_cal_store(o_nv),
      .o_nv_cal_data(o_nvd), .o_adc_chan_en(o_en),
      .o_adc_repeat_en(o_rep), .o_adc_start(o_start), .o_adc_chan(o_chan));
   // Free-running core clock, 40 ns
   initial begin
      i_core_clk = 0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   // Compare helper, design values kept four-state
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task summarize;
      if (err_total == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // One-cycle strobes, outputs looked at once settled
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_addr <= a; i_wdata <= d; i_wr <= 1;
      @(posedge i_core_clk);
      i_wr <= 0;
      #1;
   endtask
   task rd(input logic [7:0] a);
      @(posedge i_core_clk);
      i_addr <= a; i_rd <= 1;
      @(posedge i_core_clk);
      i_rd <= 0;
      #1;
   endtask
   // One-cycle sample pulse, v = {temp, aux, cur} valids
   task smp(input logic [5:0] v, input logic [11:0] d);
      @(posedge i_core_clk);
      {i_temp_data, i_cur_data, i_aux_data} <= {3{d}};
      {i_temp_valid, i_aux_valid, i_cur_valid} <= v;
      @(posedge i_core_clk);
      {i_temp_valid, i_aux_valid, i_cur_valid} <= 6'h00;
      #1;
   endtask
   // Bounded wait on calibration activity, timeout ends the run
   task wt(input logic [1:0] v);
      int n;
      for (n = 0; n < 100 && o_act !== v; n++) @(posedge i_core_clk) #1;
      if (o_act !== v) begin
         err_total++;
         summarize();
      end
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {i_rst, i_wr, i_rd, i_tracking_mode, i_adc_done} = 5'h10;
      {i_addr, i_wdata, i_ch_pd, i_temp_valid, i_cur_valid} = 0;
      {i_aux_valid, i_temp_data, i_cur_data, i_aux_data} = 0;
      {err_total, samples_checked} = 0;
      repeat (3) @(posedge i_core_clk);
      i_rst <= 0;
      wr(gbc_pkg::OFS_DAC_STAGE1_1, 16'hf123);
      chk(g1, 0); chk(o_trig, 0);
      wr(gbc_pkg::OFS_LOAD_DAC, 16'h0001);
      chk(g1, 16'h0123);
      wr(gbc_pkg::OFS_DAC_DIRECT_2, 16'hfabc);
      chk(g2, 16'h0abc); chk(o_trig, 0);
      chk(o_nv, 0);
      wr(gbc_pkg::OFS_DAC_STAGE1_2, 16'h0555);
      chk(g2, 16'h0abc);
      wr(gbc_pkg::OFS_LOAD_DAC, 16'h0002);
      chk(g2, 16'h0555); chk(g1, 16'h0123);
      rd(gbc_pkg::OFS_DAC_STAGE1_1);
      chk(o_rdata, 0);
      rd(8'hfc);
      chk(o_rdata, 0);
      wr(gbc_pkg::OFS_SETPOINT, 16'h0100);
      chk(o_trig, 2'h3);
      wr(gbc_pkg::OFS_SW_CONFIG, 16'h0008);
      wr(gbc_pkg::OFS_PARAM_1, 16'h0005);
      chk(o_trig, 2'h1);
      // Drain-current samples, source 10; code 01 is never written
      wr(gbc_pkg::OFS_SW_CONFIG, 16'h000a);
      smp(6'h01, 12'h100);
      chk(o_trig, 2'h1);
      // Enables cleared before the hysteresis moves
      wr(gbc_pkg::OFS_SW_CONFIG, 16'h0000);
      wr(gbc_pkg::OFS_HYST, 16'h000f);
      wr(gbc_pkg::OFS_SW_CONFIG, 16'h000a);
      smp(6'h01, 12'h10f);
      chk(o_trig, 0);
      smp(6'h01, 12'h110);
      chk(o_trig, 2'h1);
      // Auxiliary source 11 ignores drain current
      wr(gbc_pkg::OFS_SW_CONFIG, 16'h000b);
      smp(6'h01, 12'h400);
      chk(o_trig, 0);
      smp(6'h04, 12'h200);
      chk(o_trig, 2'h1);
      // Channel 2 average: rate bit set, but 1/16 until tracking
      wr(gbc_pkg::OFS_SW_CONFIG, 16'h8400);
      smp(6'h20, 12'h100);
      chk(o_trig, 0);
      rd(gbc_pkg::OFS_CH2_AVG);
      chk(o_rdata, 16'h0010);
      smp(6'h20, 12'h100);
      chk(o_trig, 2'h2);
      rd(gbc_pkg::OFS_CH2_AVG);
      chk(o_rdata, 16'h001f);
      @(posedge i_core_clk);
      i_tracking_mode <= 1;
      repeat (2) @(posedge i_core_clk);
      smp(6'h20, 12'h100);
      chk(o_trig, 0);
      rd(gbc_pkg::OFS_CH2_AVG);
      chk(o_rdata, 16'h0057);
      wr(gbc_pkg::OFS_SW_CONFIG, 16'hb400);
      smp(6'h20, 12'h100);
      rd(gbc_pkg::OFS_CH2_AVG);
      chk(o_rdata, 16'h0059);
      // Manual calibration, upper bits must be dropped
      wr(gbc_pkg::OFS_CAL_CONTROL, 16'hfffa);
      chk(o_nv, 1); chk(o_nvd, 3'h2);
      chk(o_cal_track, 0);
      wt(2'h1); wt(2'h2); wt(2'h0);
      rd(gbc_pkg::OFS_STATUS);
      chk(o_rdata[1], 0);
      // Periodic run comes back after the wait
      wr(gbc_pkg::OFS_CAL_CONTROL, 16'h0006);
      wt(2'h1); wt(2'h2); wt(2'h0); wt(2'h1);
      wr(gbc_pkg::OFS_CAL_CONTROL, 16'h0000);
      wt(2'h0);
      // Channel 1 powered down: straight to channel 2
      @(posedge i_core_clk);
      i_ch_pd <= 2'h1;
      wr(gbc_pkg::OFS_CAL_CONTROL, 16'h0003);
      chk(o_cal_track, 1);
      @(posedge i_core_clk) #1 chk(o_act, 2'h2);
      wt(2'h0);
      wr(gbc_pkg::OFS_ADC_SELECT, 16'hff05);
      chk(o_en, 7'h05); chk(o_rep, 0);
      chk(o_start, 1); chk(o_chan, 3'h0);
      wr(gbc_pkg::OFS_ADC_SELECT, 16'h0080);
      chk(o_rep, 1); chk(o_start, 0);
      wr(gbc_pkg::OFS_ADC_SELECT, 16'h0085);
      chk(o_start, 1); chk(o_chan, 3'h2);
      @(posedge i_core_clk);
      i_adc_done <= 1;
      @(posedge i_core_clk);
      i_adc_done <= 0;
      #1 chk(o_start, 1); chk(o_chan, 3'h0);
      summarize();
   end
endmodule
`default_nettype wire
